/* File: hdl/group_inhibit_shutdown_control.v */
// Group inhibit, hot swap reprogramming and shutdown control with I2C slave.
`timescale 1ns/10ps
`include "group_inhibit_map.vh"
module group_inhibit_shutdown_control #(
   parameter [15:0] SHUTDOWN_CYCLES = `SHUTDOWN_CYCLES,
   parameter [15:0] CROWBAR_CYCLES  = `CROWBAR_CYCLES,
   parameter [9:0]  INHIBIT_CYCLES  = `INHIBIT_CYCLES
) (
   input  wire        clk_sys,
   input  wire        rst,
   input  wire [3:0]  hotSwapInputN,
   input  wire        acLossInputN,
   input  wire        softShutdownInputN,
   input  wire        coldResetInputN,
   input  wire [3:0]  interruptModeReprog,
   input  wire [15:0] inhibitTargets,
   input  wire        autoTurnOn,
   input  wire        crowbarEnable,
   input  wire        crowbarFault,
   input  wire [2:0]  addrSelect,
   input  wire        programDone,
   input  wire [3:0]  okLineIn,
   output reg  [3:0]  okLineOut,
   output reg  [3:0]  okLineOe,
   output reg         frontEndEnableOut,
   output reg         crowbarTriggerOut,
   output reg         programStart,
   output reg  [3:0]  programMask,
   output reg         programStatusClear,
   output reg         runTimeSave,
   output reg         acLossFlag,
   output reg         softShutdownFlag,
   input  wire        sclIn,
   output reg         sclOut,
   output reg         sclOe,
   input  wire        sdaIn,
   output reg         sdaOut,
   output reg         sdaOe
);

   // ----------------------------------------------------------------------------
   // Input synchronisation
   // ----------------------------------------------------------------------------
   wire [8:0] syncBus;
   wire [3:0] hotSync;
   wire       acSync;
   wire       softSync;
   wire       coldSync;
   wire       sclSync;
   wire       sdaSync;

   sync_two_flop #(
      .WIDTH   (9)
   ) u_sync (
      .clk_sys (clk_sys),
      .rst     (rst),
      .asyncIn ({hotSwapInputN, acLossInputN, softShutdownInputN, coldResetInputN,
                 sclIn, sdaIn}),
      .syncOut (syncBus)
   );

   assign hotSync  = syncBus[8:5];
   assign acSync   = syncBus[4];
   assign softSync = syncBus[3];
   assign coldSync = syncBus[2];
   assign sclSync  = syncBus[1];
   assign sdaSync  = syncBus[0];

   // Cold reset synchronously clears the delay, crowbar and sequencing state (not programMask); the I2C slave only drops to idle.
   wire coldActive = ~coldSync;

   // ----------------------------------------------------------------------------
   // Inhibit delay, one counter per interrupt input
   // ----------------------------------------------------------------------------
   wire [3:0] inhibitDelayed;

   genvar gi;
   generate
      for (gi = 0; gi < 4; gi = gi + 1) begin : g_inhibit
         reg [9:0] delayCnt_reg;
         reg       delayed_reg;
         // A trigger-mode input never counts, so one input cannot do both jobs.
         always @(posedge clk_sys or posedge rst) begin
            if (rst) begin
               delayCnt_reg <= 10'h000;
               delayed_reg  <= 1'b0;
            end else if (coldActive || hotSync[gi] || interruptModeReprog[gi]) begin
               delayCnt_reg <= 10'h000;
               delayed_reg  <= 1'b0;
            end else if (delayCnt_reg == INHIBIT_CYCLES - 10'h001) begin
               delayed_reg  <= 1'b1;
            end else begin
               delayCnt_reg <= delayCnt_reg + 10'h001;
            end
         end
         assign inhibitDelayed[gi] = delayed_reg;
      end
   endgenerate

   // Maps delayed inhibits onto groups: input i targets groups inhibitTargets[4i+3:4i].
   function [3:0] inhibitGroups;
      input [3:0]  active;
      input [15:0] targets;
      integer k;
      begin
         inhibitGroups = 4'h0;
         for (k = 0; k < 4; k = k + 1) begin
            if (active[k]) begin
               inhibitGroups = inhibitGroups | targets[4*k +: 4];
            end
         end
      end
   endfunction

   wire [3:0] inhibitMask = inhibitGroups(inhibitDelayed, inhibitTargets);

   // ----------------------------------------------------------------------------
   // AC-loss and soft shutdown delay
   // ----------------------------------------------------------------------------
   reg  [15:0] shutCnt_reg;
   reg         shutDelayed_reg;
   reg         shutPrev_reg;
   wire        shutLow = ~acSync | ~softSync;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         shutCnt_reg     <= 16'h0000;
         shutDelayed_reg <= 1'b0;
         shutPrev_reg    <= 1'b0;
      end else begin
         shutPrev_reg <= shutDelayed_reg;
         if (coldActive || !shutLow) begin
            shutCnt_reg     <= 16'h0000;
            shutDelayed_reg <= 1'b0;
         end else if (shutCnt_reg == SHUTDOWN_CYCLES - 16'h0001) begin
            shutDelayed_reg <= 1'b1;
         end else begin
            shutCnt_reg <= shutCnt_reg + 16'h0001;
         end
      end
   end

   wire shutAssert  = shutDelayed_reg & ~shutPrev_reg;
   wire shutRelease = ~shutDelayed_reg & shutPrev_reg;

   // ----------------------------------------------------------------------------
   // I2C slave
   // ----------------------------------------------------------------------------
   localparam [2:0] S_IDLE = 3'h0;
   localparam [2:0] S_ADDR = 3'h1;
   localparam [2:0] S_ACK  = 3'h2;
   localparam [2:0] S_WR   = 3'h3;
   localparam [2:0] S_RD   = 3'h4;
   localparam [2:0] S_RACK = 3'h5;

   reg  [2:0] i2cState_reg;
   reg  [3:0] bitCnt_reg;
   reg  [7:0] shift_reg;
   reg  [7:0] tx_reg;
   reg        readMode_reg;
   reg        masterAck_reg;
   reg        sclPrev_reg;
   reg        sdaPrev_reg;
   reg        cmdValid_reg;
   reg  [7:0] cmdByte_reg;

   wire sclRise  = sclSync & ~sclPrev_reg;
   wire sclFall  = ~sclSync & sclPrev_reg;
   wire busStart = sclSync & sclPrev_reg & sdaPrev_reg & ~sdaSync;
   wire busStop  = sclSync & sclPrev_reg & ~sdaPrev_reg & sdaSync;
   wire [7:0] statusByte = {okLineIn, softShutdownFlag, acLossFlag, shutDelayed_reg,
                            frontEndEnableOut};

   // Both bus rates are served; sampling at 50 MHz leaves ample margin at 400 kbit/s.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         i2cState_reg  <= S_IDLE;
         bitCnt_reg    <= 4'h0;
         shift_reg     <= 8'h00;
         tx_reg        <= 8'h00;
         readMode_reg  <= 1'b0;
         masterAck_reg <= 1'b0;
         sclPrev_reg   <= 1'b1;
         sdaPrev_reg   <= 1'b1;
         cmdValid_reg  <= 1'b0;
         cmdByte_reg   <= 8'h00;
         sdaOe         <= 1'b0;
         sdaOut        <= 1'b0;
         sclOe         <= 1'b0;
         sclOut        <= 1'b0;
      end else if (coldActive) begin
         i2cState_reg <= S_IDLE;
         cmdValid_reg <= 1'b0;
         sdaOe        <= 1'b0;
      end else begin
         sclPrev_reg  <= sclSync;
         sdaPrev_reg  <= sdaSync;
         cmdValid_reg <= 1'b0;
         if (busStart) begin
            i2cState_reg <= S_ADDR;
            bitCnt_reg   <= 4'h0;
            sdaOe        <= 1'b0;
         end else if (busStop) begin
            i2cState_reg <= S_IDLE;
            sdaOe        <= 1'b0;
         end else begin
            case (i2cState_reg)
               S_ADDR, S_WR: begin
                  if (sclRise) begin
                     shift_reg  <= {shift_reg[6:0], sdaSync};
                     bitCnt_reg <= bitCnt_reg + 4'h1;
                  end else if (sclFall && bitCnt_reg == 4'h8) begin
                     if (i2cState_reg == S_WR) begin
                        cmdValid_reg <= 1'b1;
                        cmdByte_reg  <= shift_reg;
                        sdaOe        <= 1'b1;
                        i2cState_reg <= S_ACK;
                     end else if (shift_reg[7:1] == {`SLAVE_ADDR_PREFIX, addrSelect}) begin
                        readMode_reg <= shift_reg[0];
                        sdaOe        <= 1'b1;
                        i2cState_reg <= S_ACK;
                     end else begin
                        i2cState_reg <= S_IDLE;
                     end
                  end
               end
               S_ACK: begin
                  if (sclFall) begin
                     bitCnt_reg <= 4'h0;
                     if (readMode_reg) begin
                        tx_reg       <= statusByte;
                        sdaOe        <= ~statusByte[7];
                        i2cState_reg <= S_RD;
                     end else begin
                        sdaOe        <= 1'b0;
                        i2cState_reg <= S_WR;
                     end
                  end
               end
               S_RD: begin
                  if (sclFall) begin
                     bitCnt_reg <= bitCnt_reg + 4'h1;
                     if (bitCnt_reg == 4'h7) begin
                        sdaOe        <= 1'b0;
                        i2cState_reg <= S_RACK;
                     end else begin
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        sdaOe  <= ~tx_reg[6];
                     end
                  end
               end
               S_RACK: begin
                  if (sclRise) begin
                     masterAck_reg <= ~sdaSync;
                  end else if (sclFall) begin
                     bitCnt_reg <= 4'h0;
                     if (masterAck_reg) begin
                        tx_reg       <= statusByte;
                        sdaOe        <= ~statusByte[7];
                        i2cState_reg <= S_RD;
                     end else begin
                        i2cState_reg <= S_IDLE;
                     end
                  end
               end
               default: begin
                  i2cState_reg <= S_IDLE;
                  sdaOe        <= 1'b0;
               end
            endcase
         end
      end
   end

   wire [3:0] cmdCode = cmdByte_reg[`CMD_FIELD_MSB:`CMD_FIELD_LSB];
   wire [3:0] cmdArg  = cmdByte_reg[3:0];

   // ----------------------------------------------------------------------------
   // Group sequencing and programming
   // ----------------------------------------------------------------------------
   reg  [3:0] hotPrev_reg;
   reg  [3:0] groupOn_reg;
   reg  [3:0] pending_reg;
   reg  [3:0] active_reg;
   reg        busy_reg;

   // Input n is bound to group n; there is no routing choice here.
   wire [3:0] reprogFall = hotPrev_reg & ~hotSync & interruptModeReprog;
   wire [3:0] reprogRise = ~hotPrev_reg & hotSync & interruptModeReprog;
   // Trigger-mode groups with the card absent stay off after a global program.
   wire [3:0] turnOnMask = active_reg & ~(interruptModeReprog & hotSync);

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         hotPrev_reg        <= 4'hf;
         groupOn_reg        <= 4'h0;
         pending_reg        <= `RESET_PENDING_MASK;
         active_reg         <= 4'h0;
         busy_reg           <= 1'b0;
         programStart       <= 1'b0;
         programMask        <= 4'h0;
         programStatusClear <= 1'b0;
         runTimeSave        <= 1'b0;
         acLossFlag         <= 1'b0;
         softShutdownFlag   <= 1'b0;
         frontEndEnableOut  <= 1'b0;
         okLineOe           <= 4'hf;
         okLineOut          <= 4'h0;
      end else if (coldActive) begin
         hotPrev_reg        <= 4'hf;
         groupOn_reg        <= 4'h0;
         pending_reg        <= `RESET_PENDING_MASK;
         active_reg         <= 4'h0;
         busy_reg           <= 1'b0;
         programStart       <= 1'b0;
         programStatusClear <= 1'b0;
         runTimeSave        <= 1'b0;
         acLossFlag         <= 1'b0;
         softShutdownFlag   <= 1'b0;
         frontEndEnableOut  <= 1'b0;
         okLineOe           <= 4'hf;
      end else begin
         hotPrev_reg        <= hotSync;
         programStart       <= 1'b0;
         programStatusClear <= 1'b0;
         runTimeSave        <= 1'b0;
         if (!frontEndEnableOut && !busy_reg && pending_reg == `RESET_PENDING_MASK &&
             groupOn_reg == 4'h0 && active_reg == 4'h0 && !acLossFlag && !softShutdownFlag) begin
            frontEndEnableOut <= `RESET_FRONT_END;
         end
         // Programming runs even under an inhibit; only a global shutdown defers it.
         if (busy_reg) begin
            if (programDone) begin
               busy_reg <= 1'b0;
               if (autoTurnOn) begin
                  groupOn_reg <= groupOn_reg | turnOnMask;
               end
            end
         end else if (pending_reg != 4'h0 && !shutDelayed_reg) begin
            programStart <= 1'b1;
            programMask  <= pending_reg;
            active_reg   <= pending_reg;
            busy_reg     <= 1'b1;
         end
         if (!busy_reg && pending_reg != 4'h0 && !shutDelayed_reg) begin
            pending_reg <= reprogFall;
         end else begin
            pending_reg <= (pending_reg | reprogFall) & ~reprogRise;
         end
         if (cmdValid_reg) begin
            case (cmdCode)
               `CMD_GROUP_ON:    groupOn_reg       <= groupOn_reg | cmdArg;
               `CMD_GROUP_OFF:   groupOn_reg       <= groupOn_reg & ~cmdArg;
               `CMD_FRONT_END:   frontEndEnableOut <= cmdArg[0];
               default:          groupOn_reg       <= groupOn_reg;
            endcase
         end
         if (reprogRise != 4'h0) begin
            groupOn_reg        <= groupOn_reg & ~reprogRise;
            active_reg         <= active_reg & ~reprogRise;
            programStatusClear <= 1'b1;
         end
         if (shutAssert) begin
            groupOn_reg        <= 4'h0;
            programStatusClear <= 1'b1;
            runTimeSave        <= 1'b1;
         end
         if (shutRelease) begin
            pending_reg <= 4'hf;
            active_reg  <= 4'h0;
            busy_reg    <= 1'b0;
         end
         // Setting wins over a host clear arriving in the same cycle.
         if (shutDelayed_reg && !acSync) begin
            acLossFlag <= 1'b1;
         end else if (cmdValid_reg && cmdCode == `CMD_CLEAR_FLAGS) begin
            acLossFlag <= 1'b0;
         end
         if (shutDelayed_reg && !softSync) begin
            softShutdownFlag <= 1'b1;
         end else if (cmdValid_reg && cmdCode == `CMD_CLEAR_FLAGS) begin
            softShutdownFlag <= 1'b0;
         end
         // Each source pulls low on its own, so a line is freed only once every source has released it.
         okLineOe <= ~groupOn_reg | inhibitMask | {4{shutDelayed_reg}};
      end
   end

   // ----------------------------------------------------------------------------
   // Crowbar pulse
   // ----------------------------------------------------------------------------
   reg [15:0] crowbarCnt_reg;
   reg        faultPrev_reg;

   // A new fault during a running pulse does not extend it: one pulse only.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         crowbarCnt_reg    <= 16'h0000;
         faultPrev_reg     <= 1'b0;
         crowbarTriggerOut <= 1'b0;
      end else if (coldActive) begin
         crowbarCnt_reg    <= 16'h0000;
         faultPrev_reg     <= 1'b0;
         crowbarTriggerOut <= 1'b0;
      end else begin
         faultPrev_reg <= crowbarFault;
         if (crowbarTriggerOut) begin
            if (crowbarCnt_reg == CROWBAR_CYCLES - 16'h0001) begin
               crowbarTriggerOut <= 1'b0;
               crowbarCnt_reg    <= 16'h0000;
            end else begin
               crowbarCnt_reg <= crowbarCnt_reg + 16'h0001;
            end
         end else if (crowbarEnable && crowbarFault && !faultPrev_reg) begin
            crowbarTriggerOut <= 1'b1;
         end
      end
   end

endmodule

/* File: hdl/group_inhibit_map.vh */
// Constants for the group inhibit and shutdown control block.
// Summary of operation
// - Four interrupt inputs, each either group inhibit or group reprogramming trigger.
// - Automatic turn-on bit decides whether groups start without a host command.
// - Low inhibit input holds OK lines of all its targeted groups low.
// - Inhibit released high lets targeted OK lines go and groups restart.
// - Converter programming still proceeds while an inhibit input is held low.
// - Inhibit falling edge to OK lines low takes about 10 microseconds.
// - Reprogramming trigger n acts only on group n; the mapping is fixed.
// - Trigger low programs its group, then turns it on if auto turn-on.
// - Trigger release pulls its OK line low and clears programming status.
// - AC-loss or soft shutdown low pulls every OK line low.
// - Shutdown also clears programming status, saves run time, flags its source.
// - Shutdown release programs all, turns on if auto, else waits for host.
// - AC-loss or soft shutdown falling to OK lines low takes about 1 ms.
// - Front-end enable output follows host enable and disable commands.
// - Enabled, triggered crowbar gives one high pulse of 1 ms.
// - Cold reset low resets all but programMask and the I2C slave, which only drops to idle; other outputs off; release programs all groups.
// - On I2C the device is always slave, at 100 and 400 kbit/s.
// - Slave address: four fixed upper bits, three from address select pins.
`ifndef GROUP_INHIBIT_MAP_VH
`define GROUP_INHIBIT_MAP_VH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS        20
`define INHIBIT_DELAY_NS     10000
`define SHUTDOWN_DELAY_NS    1000000
`define CROWBAR_PULSE_NS     1000000
// Counts are the delays above over the clock period, sized to the counters that hold them.
`define INHIBIT_CYCLES       10'h1f4
`define SHUTDOWN_CYCLES      16'hc350
`define CROWBAR_CYCLES       16'hc350

// ----------------------------------------------------------------------------
// I2C slave address and host command byte
// ----------------------------------------------------------------------------
`define SLAVE_ADDR_PREFIX    4'h5
`define CMD_FIELD_MSB        7
`define CMD_FIELD_LSB        4
`define CMD_GROUP_ON         4'h1
`define CMD_GROUP_OFF        4'h2
`define CMD_FRONT_END        4'h3
`define CMD_CLEAR_FLAGS      4'h4

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RESET_PENDING_MASK   4'hf
`define RESET_FRONT_END      1'b1

`endif

/* File: hdl/sync_two_flop.v */
// Two flip-flop synchroniser for a group of asynchronous level inputs.
`timescale 1ns/10ps
module sync_two_flop #(
   parameter WIDTH = 1
) (
   input  wire             clk_sys,
   input  wire             rst,
   input  wire [WIDTH-1:0] asyncIn,
   output wire [WIDTH-1:0] syncOut
);

   // Inputs here idle high, so the chain resets to ones to avoid a false low.
   reg [WIDTH-1:0] stage1_reg;
   reg [WIDTH-1:0] stage2_reg;

   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stage1_reg <= {WIDTH{1'b1}};
         stage2_reg <= {WIDTH{1'b1}};
      end else begin
         stage1_reg <= asyncIn;
         stage2_reg <= stage1_reg;
      end
   end

   assign syncOut = stage2_reg;

endmodule

/* File: tb/shutdown_control_properties.sv */
// Concurrent checks on the shutdown control ports.
`timescale 1ns/10ps
module shutdown_control_properties #(
   parameter [15:0] SHUTDOWN_CYCLES = 16'h0014,
   parameter [15:0] CROWBAR_CYCLES  = 16'h0014,
   parameter [9:0]  INHIBIT_CYCLES  = 10'h008
) (
   input wire        clk_sys,
   input wire        rst,
   input wire [3:0]  hotSwapInputN,
   input wire        acLossInputN,
   input wire        softShutdownInputN,
   input wire        coldResetInputN,
   input wire [3:0]  interruptModeReprog,
   input wire [15:0] inhibitTargets,
   input wire        crowbarEnable,
   input wire [3:0]  okLineOut,
   input wire [3:0]  okLineOe,
   input wire        frontEndEnableOut,
   input wire        crowbarTriggerOut,
   input wire        programStatusClear,
   input wire        runTimeSave,
   input wire        acLossFlag
);
   int crowCnt_reg;
   int inhCnt_reg;
   int sdCnt_reg;
   // The margins of six cycles cover the two-flop input synchronisers.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         crowCnt_reg <= 0;
         inhCnt_reg  <= 0;
         sdCnt_reg   <= 0;
      end else begin
         crowCnt_reg <= crowbarTriggerOut ? crowCnt_reg + 1 : 0;
         inhCnt_reg  <= (!hotSwapInputN[1] && !interruptModeReprog[1]) ? inhCnt_reg + 1 : 0;
         sdCnt_reg   <= (!acLossInputN || !softShutdownInputN) ? sdCnt_reg + 1 : 0;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   okline_drive_a: assert property (
      okLineOut == 4'h0) else $error("OK line driven high");
   inhibit_hold_a: assert property (
      inhCnt_reg > INHIBIT_CYCLES + 6 |-> (okLineOe & inhibitTargets[7:4]) == inhibitTargets[7:4])
      else $error("Inhibited groups not held off");
   shutdown_all_a: assert property (
      sdCnt_reg > SHUTDOWN_CYCLES + 6 |-> okLineOe == 4'hf) else $error("Shutdown left a group on");
   shutdown_side_a: assert property (
      $rose(runTimeSave) |-> programStatusClear && okLineOe == 4'hf)
      else $error("Run time save without status clear");
   flag_set_a: assert property (
      $rose(acLossFlag) |-> okLineOe == 4'hf) else $error("Flag set without shutdown");
   crowbar_len_a: assert property (
      $fell(crowbarTriggerOut) |-> crowCnt_reg == CROWBAR_CYCLES) else $error("Crowbar pulse length");
   crowbar_cause_a: assert property (
      $rose(crowbarTriggerOut) |-> $past(crowbarEnable)) else $error("Crowbar while disabled");
   cold_clear_a: assert property (
      !coldResetInputN [*5] |-> okLineOe == 4'hf && !frontEndEnableOut)
      else $error("Cold reset left outputs on");
   reprog_drop_a: assert property (
      $rose(hotSwapInputN[2]) && interruptModeReprog[2] |-> ##[1:6] okLineOe[2])
      else $error("Trigger release left group on");
endmodule

/* File: tb/prog_agent_model.sv */
// Programming agent and converter model on the far side of the OK lines.
`timescale 1ns/10ps
module prog_agent_model (
   input  wire       clk_sys,
   input  wire       rst,
   input  wire       slowMode,
   input  wire       programStart,
   input  wire [3:0] okLineOe,
   output reg        programDone,
   output reg  [3:0] okLineIn
);
   int waitCnt_reg;
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         waitCnt_reg <= 0;
         programDone <= 1'b0;
         okLineIn    <= 4'h0;
      end else begin
         okLineIn    <= ~okLineOe;
         programDone <= (waitCnt_reg == 1);
         if (programStart)
            waitCnt_reg <= slowMode ? 30 : 3;
         else if (waitCnt_reg != 0)
            waitCnt_reg <= waitCnt_reg - 1;
      end
   end
endmodule

/* File: tb/group_inhibit_shutdown_control_tb.sv */
// Self-checking bench for the group inhibit and shutdown control.
`timescale 1ns/10ps
module group_inhibit_shutdown_control_tb;
   localparam int SD = 20;
   logic clk_sys = 1'b0, rst = 1'b1, acN = 1'b1, softN = 1'b1, coldN = 1'b1, auto = 1'b1;
   logic crowEn = 1'b0, crowFault = 1'b0, slowMode = 1'b0, programDone, programStart;
   logic frontEnd, crowOut, clr, save, acFlag, softFlag, sclOe, sdaOe;
   logic [3:0] hsN = 4'hf, mode = 4'h0, okLineIn, okLineOe, mask, seenMask = 4'h0, crowHigh = 4'h0;
   logic [2:0] seenPulse = 3'h0;
   logic [15:0] targets = 16'h0000;
   int n_mismatch = 0;
   int checks_done = 0;
   always #10 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (programStart) seenMask <= mask;
      seenPulse <= seenPulse | {clr, save, programStart};
      crowHigh <= crowHigh + {3'h0, crowOut};
   end
   group_inhibit_shutdown_control #(.SHUTDOWN_CYCLES(16'h0014), .CROWBAR_CYCLES(16'h000c),
      .INHIBIT_CYCLES(10'h008)) group_inhibit_shutdown_control_i (.clk_sys, .rst,
      .hotSwapInputN(hsN), .acLossInputN(acN), .softShutdownInputN(softN),
      .coldResetInputN(coldN), .interruptModeReprog(mode), .inhibitTargets(targets),
      .autoTurnOn(auto), .crowbarEnable(crowEn), .crowbarFault(crowFault), .addrSelect(3'h0),
      .programDone, .okLineIn, .okLineOut(), .okLineOe, .frontEndEnableOut(frontEnd),
      .crowbarTriggerOut(crowOut), .programStart, .programMask(mask), .programStatusClear(clr),
      .runTimeSave(save), .acLossFlag(acFlag), .softShutdownFlag(softFlag), .sclIn(~sclOe),
      .sclOut(), .sclOe, .sdaIn(~sdaOe), .sdaOut(), .sdaOe);
   prog_agent_model prog_agent_model_i (.clk_sys, .rst, .slowMode, .programStart, .okLineOe,
      .programDone, .okLineIn);
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic check(input string what, input logic [3:0] exp, input logic [3:0] got);
      checks_done++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Samples one step after the edge so that the edge's own updates have landed.
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic wait_ok(input logic [3:0] exp, input int lim);
      int i;
      for (i = 0; i < lim && okLineOe !== exp; i++) cyc(1);
      check("okLineOe", exp, okLineOe);
      if (okLineOe !== exp) report_and_stop();
   endtask
   task automatic t_inhibit();
      @(posedge clk_sys);
      mode <= 4'h4;
      targets <= 16'h0f30;
      hsN <= 4'h9;
      cyc(8);
      check("okEarly", 4'h0, okLineOe);
      wait_ok(4'h3, 12);
      check("progMask", 4'h4, seenMask);
      @(posedge clk_sys) hsN <= 4'hb;
      wait_ok(4'h0, 8);
      seenPulse = 3'h0;
      @(posedge clk_sys) hsN <= 4'hf;
      wait_ok(4'h4, 6);
      check("statusClear", 4'h4, {1'b0, seenPulse});
      @(posedge clk_sys) hsN <= 4'hb;
      wait_ok(4'h0, 20);
   endtask
   task automatic t_shutdown();
      for (int src = 0; src < 2; src++) begin
         seenPulse = 3'h0;
         @(posedge clk_sys);
         slowMode <= src[0];
         if (src == 0) acN <= 1'b0;
         else softN <= 1'b0;
         cyc(SD - 2);
         check("okBeforeDelay", 4'h0, okLineOe);
         wait_ok(4'hf, 12);
         cyc(1);
         check("pulses", 4'h6, {1'b0, seenPulse});
         check("flags", {2'h0, src[0], 1'b1}, {2'h0, softFlag, acFlag});
         @(posedge clk_sys) {acN, softN} <= 2'h3;
         wait_ok(4'h0, 80);
         check("allMask", 4'hf, seenMask);
      end
   endtask
   task automatic t_crowbar();
      @(posedge clk_sys) crowFault <= 1'b1;
      cyc(3);
      check("crowOff", 4'h0, crowHigh);
      @(posedge clk_sys) crowFault <= 1'b0;
      crowEn <= 1'b1;
      @(posedge clk_sys) crowFault <= 1'b1;
      cyc(4);
      @(posedge clk_sys) crowFault <= 1'b0;
      @(posedge clk_sys) crowFault <= 1'b1;
      cyc(16);
      check("crowLen", 4'hc, crowHigh);
   endtask
   task automatic t_cold();
      @(posedge clk_sys);
      auto <= 1'b0;
      {acN, softN} <= 2'h0;
      wait_ok(4'hf, SD + 10);
      @(posedge clk_sys) acN <= 1'b1;
      cyc(10);
      check("okHeld", 4'hf, okLineOe);
      @(posedge clk_sys) softN <= 1'b1;
      cyc(60);
      check("okWaitHost", 4'hf, okLineOe);
      // Cold reset is kept for the last scenario, as a system would use it.
      @(posedge clk_sys) coldN <= 1'b0;
      auto <= 1'b1;
      cyc(6);
      check("feOff", 4'h0, {3'h0, frontEnd});
      @(posedge clk_sys) coldN <= 1'b1;
      wait_ok(4'h0, 80);
   endtask
   initial begin
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      wait_ok(4'h0, 60);
      check("feOn", 4'h1, {3'h0, frontEnd});
      check("startMask", 4'hf, seenMask);
      t_inhibit();
      t_shutdown();
      t_crowbar();
      t_cold();
      check("sdaIdle", 4'h0, {2'h0, sclOe, sdaOe});
      report_and_stop();
   end
endmodule
bind group_inhibit_shutdown_control shutdown_control_properties #(
   .SHUTDOWN_CYCLES(SHUTDOWN_CYCLES), .CROWBAR_CYCLES(CROWBAR_CYCLES),
   .INHIBIT_CYCLES(INHIBIT_CYCLES)) shutdown_control_properties_i (.clk_sys, .rst,
   .hotSwapInputN, .acLossInputN, .softShutdownInputN, .coldResetInputN,
   .interruptModeReprog, .inhibitTargets, .crowbarEnable, .okLineOut, .okLineOe,
   .frontEndEnableOut, .crowbarTriggerOut, .programStatusClear, .runTimeSave, .acLossFlag);
